/* core/pss_pkg.sv */
package pss_pkg;

	// clock and timing
	localparam int CLK_MHZ           = 100;
	localparam int SEQ_TIME_US       = 2500;
	localparam int SEQ_CYCLES        = SEQ_TIME_US * CLK_MHZ;
	localparam int WAKE_LOW_TIME_US  = 100;
	localparam int WAKE_LOW_CYCLES   = WAKE_LOW_TIME_US * CLK_MHZ;
	localparam int CNT_W             = 20;
	localparam int GP_NUM            = 5;
	localparam int APD_W             = 8;

	// register offsets
	localparam logic [7:0] OFS_PCON  = 8'h00;
	localparam logic [7:0] OFS_CTRL  = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_PDCFG = 8'h0C;
	localparam logic [7:0] OFS_GP0   = 8'h10;

	// power control fields
	localparam int PCON_MODE_LSB     = 0;
	localparam int PCON_SLEEP_FLAG   = 2;
	localparam int PCON_DPD_FLAG     = 3;
	localparam int PCON_AUTO_DIS     = 4;
	localparam int PCON_BAT_OFF      = 5;

	// control fields
	localparam int CTRL_BOD_EN       = 0;
	localparam int CTRL_WAKE_EN      = 1;
	localparam int CTRL_FIELD_WAKE   = 2;
	localparam int CTRL_CORE_EN      = 3;
	localparam int CTRL_ANA_EN       = 4;

	// reset values
	localparam logic [4:0]       CTRL_RST  = 5'h18;
	localparam logic [APD_W-1:0] PDCFG_RST = 8'hFF;

	// processor-selected low power mode
	localparam logic [1:0] SEL_SLEEP  = 2'h0;
	localparam logic [1:0] SEL_DSLEEP = 2'h1;

	typedef enum logic [2:0] {
		ST_OFF, ST_CORE, ST_ANALOG, ST_BOOT, ST_ACTIVE, ST_SLEEP, ST_DSLEEP, ST_DPD
	} pss_state_t;

	typedef struct packed {
		logic bat_ok;
		logic field_ok;
		logic always_on_low;
		logic external_reset_pin;
		logic wake_pin;
		logic rtc_preset;
		logic wdt_event;
		logic start_irq;
		logic sysosc_stable;
		logic flash_ready;
		logic cpu_sleep_req;
	} pss_in_t;

	typedef struct packed {
		logic battery_power_switch;
		logic field_power_switch;
		logic source_field;
		logic comparator_en;
		logic core_regulator_en;
		logic analog_regulator_en;
		logic system_por_n;
		logic boot_go;
		logic brownout_irq;
		logic timer_oscillator_en;
	} pss_out_t;

	typedef struct packed {
		pss_state_t                  state;
		logic [CNT_W-1:0]            cnt;
		logic [CNT_W-1:0]            wake_cnt;
		logic                        rst_pin_prev;
		logic                        bat_armed;
		logic [1:0]                  mode_sel;
		logic                        sleep_flag;
		logic                        dpd_flag;
		logic                        auto_dis;
		logic [4:0]                  ctrl;
		logic [APD_W-1:0]            apd;
		logic [GP_NUM-1:0][31:0]     gp;
		logic [31:0]                 rdata;
		logic                        boot;
	} pss_regs_t;

endpackage

/* core/pss_sequencer.sv */
`timescale 1ns/100ps
module pss_sequencer #(
	parameter int SEQ_CYCLES      = pss_pkg::SEQ_CYCLES,
	parameter int WAKE_LOW_CYCLES = pss_pkg::WAKE_LOW_CYCLES
) (
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic [7:0]                reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,
	input  pss_pkg::pss_in_t               pwr_in,
	output pss_pkg::pss_out_t              pwr_out,
	output logic      [pss_pkg::APD_W-1:0] analog_pd
);

	if (SEQ_CYCLES < 1 || SEQ_CYCLES >= 2 ** pss_pkg::CNT_W ||
	    WAKE_LOW_CYCLES < 1 || WAKE_LOW_CYCLES >= 2 ** pss_pkg::CNT_W) begin : g_chk
		$error("pss_sequencer: cycle counts out of range");
	end

	localparam logic [pss_pkg::CNT_W-1:0] SEQ_N  = pss_pkg::CNT_W'(SEQ_CYCLES);
	localparam logic [pss_pkg::CNT_W-1:0] WAKE_N = pss_pkg::CNT_W'(WAKE_LOW_CYCLES);

	pss_pkg::pss_regs_t r_r;
	pss_pkg::pss_regs_t r_nxt;

	logic        rst_rise;
	logic        powered;
	logic        use_bat;
	logic        wake_ok;
	logic        ds_wake;
	logic        dpd_wake;
	logic        core_on_st;
	logic        ana_on_st;
	logic        wr_pcon;
	logic [31:0] rd_val;

	always_comb begin
		rst_rise = pwr_in.external_reset_pin & ~r_r.rst_pin_prev;
		// battery path only after arming; auto disabled means battery forced
		use_bat  = r_r.bat_armed & (pwr_in.bat_ok | r_r.auto_dis);
		powered  = use_bat | pwr_in.field_ok;
		wake_ok  = r_r.ctrl[pss_pkg::CTRL_WAKE_EN] & (r_r.wake_cnt >= WAKE_N);
		dpd_wake = ~pwr_in.external_reset_pin | pwr_in.rtc_preset | wake_ok
			| (r_r.ctrl[pss_pkg::CTRL_FIELD_WAKE] & pwr_in.field_ok);
		ds_wake  = dpd_wake | pwr_in.wdt_event | pwr_in.start_irq;
		wr_pcon  = reg_wr & (reg_addr == pss_pkg::OFS_PCON);
		core_on_st = r_r.state inside {pss_pkg::ST_CORE, pss_pkg::ST_ANALOG, pss_pkg::ST_BOOT,
			pss_pkg::ST_ACTIVE, pss_pkg::ST_SLEEP, pss_pkg::ST_DSLEEP};
		ana_on_st  = core_on_st & (r_r.state != pss_pkg::ST_CORE);
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (reg_addr)
			pss_pkg::OFS_PCON: begin
				rd_val[5:0] = {1'b0, r_r.auto_dis, r_r.dpd_flag, r_r.sleep_flag, r_r.mode_sel};
			end
			pss_pkg::OFS_CTRL: begin
				rd_val[4:0] = r_r.ctrl;
			end
			pss_pkg::OFS_STAT: begin
				rd_val[10:0] = {r_r.state, 3'h0, r_r.bat_armed, pwr_out.brownout_irq,
					pwr_out.source_field, pwr_in.field_ok, pwr_in.bat_ok};
			end
			pss_pkg::OFS_PDCFG: begin
				rd_val[pss_pkg::APD_W-1:0] = r_r.apd;
			end
			default: begin
				for (int i = 0; i < pss_pkg::GP_NUM; i++) begin
					if (reg_addr == pss_pkg::OFS_GP0 + 8'(4 * i)) begin
						rd_val = r_r.gp[i];
					end
				end
			end
		endcase
	end

	always_comb begin
		r_nxt              = r_r;
		r_nxt.rst_pin_prev = pwr_in.external_reset_pin;
		r_nxt.boot         = 1'b0;
		r_nxt.rdata        = reg_rd ? rd_val : 32'h0000_0000;
		r_nxt.wake_cnt     = pwr_in.wake_pin ? '0 :
			(r_r.wake_cnt >= WAKE_N ? r_r.wake_cnt : r_r.wake_cnt + 1'b1);

		// software register writes
		if (reg_wr) begin
			unique case (reg_addr)
				pss_pkg::OFS_PCON: begin
					r_nxt.mode_sel = reg_wdata[pss_pkg::PCON_MODE_LSB +: 2];
					r_nxt.auto_dis = reg_wdata[pss_pkg::PCON_AUTO_DIS];
					if (reg_wdata[pss_pkg::PCON_SLEEP_FLAG]) begin
						r_nxt.sleep_flag = 1'b0;
					end
					if (reg_wdata[pss_pkg::PCON_DPD_FLAG]) begin
						r_nxt.dpd_flag = 1'b0;
					end
				end
				pss_pkg::OFS_CTRL: begin
					r_nxt.ctrl = reg_wdata[4:0];
				end
				pss_pkg::OFS_PDCFG: begin
					r_nxt.apd = reg_wdata[pss_pkg::APD_W-1:0];
				end
				default: begin
					for (int i = 0; i < pss_pkg::GP_NUM; i++) begin
						if (reg_addr == pss_pkg::OFS_GP0 + 8'(4 * i)) begin
							r_nxt.gp[i] = reg_wdata;
						end
					end
				end
			endcase
		end

		// battery switch arming and software turn-off
		if (wr_pcon && reg_wdata[pss_pkg::PCON_BAT_OFF] && !pwr_in.field_ok) begin
			r_nxt.bat_armed = 1'b0;
		end
		if (rst_rise || pwr_in.field_ok) begin
			r_nxt.bat_armed = 1'b1;
		end

		if (r_r.cnt < SEQ_N) begin
			r_nxt.cnt = r_r.cnt + 1'b1;
		end

		// power sequencer
		unique case (r_r.state)
			pss_pkg::ST_OFF: begin
				r_nxt.cnt = '0;
				if (powered) begin
					r_nxt.state = pss_pkg::ST_CORE;
				end
			end
			pss_pkg::ST_CORE: begin
				r_nxt.state = pss_pkg::ST_ANALOG;
			end
			pss_pkg::ST_ANALOG: begin
				if (pwr_in.sysosc_stable && r_r.ctrl[pss_pkg::CTRL_CORE_EN]) begin
					r_nxt.state = pss_pkg::ST_BOOT;
				end
			end
			pss_pkg::ST_BOOT: begin
				if (pwr_in.flash_ready && r_r.cnt >= SEQ_N) begin
					r_nxt.state = pss_pkg::ST_ACTIVE;
					r_nxt.boot  = 1'b1;
				end
			end
			pss_pkg::ST_ACTIVE: begin
				if (pwr_in.cpu_sleep_req) begin
					if (r_r.mode_sel == pss_pkg::SEL_SLEEP) begin
						r_nxt.state      = pss_pkg::ST_SLEEP;
						r_nxt.sleep_flag = 1'b1;
					end else if (r_r.mode_sel == pss_pkg::SEL_DSLEEP) begin
						r_nxt.state      = pss_pkg::ST_DSLEEP;
						r_nxt.sleep_flag = 1'b1;
					end else begin
						r_nxt.state    = pss_pkg::ST_DPD;
						r_nxt.dpd_flag = 1'b1;
					end
				end
			end
			pss_pkg::ST_SLEEP, pss_pkg::ST_DSLEEP: begin
				if (ds_wake) begin
					r_nxt.state = pss_pkg::ST_ACTIVE;
				end
			end
			pss_pkg::ST_DPD: begin
				if (dpd_wake) begin
					r_nxt.state = pss_pkg::ST_CORE;
					r_nxt.cnt   = '0;
				end
			end
		endcase

		// losing all supply drops to battery-off; the gp retention registers keep their values
		if (!powered) begin
			r_nxt.state = pss_pkg::ST_OFF;
			r_nxt.boot  = 1'b0;
			r_nxt.cnt   = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			r_r              <= '0;
			r_r.state        <= pss_pkg::ST_OFF;
			r_r.rst_pin_prev <= 1'b1;
			r_r.ctrl         <= pss_pkg::CTRL_RST;
			r_r.apd          <= pss_pkg::PDCFG_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	always_comb begin
		pwr_out.battery_power_switch = use_bat;
		pwr_out.field_power_switch   = pwr_in.field_ok;
		pwr_out.source_field         = ~use_bat & pwr_in.field_ok;
		pwr_out.comparator_en        = ~r_r.auto_dis;
		pwr_out.core_regulator_en    = core_on_st & r_r.ctrl[pss_pkg::CTRL_CORE_EN];
		pwr_out.analog_regulator_en  = ana_on_st & r_r.ctrl[pss_pkg::CTRL_ANA_EN];
		pwr_out.system_por_n         = ana_on_st & (r_r.state != pss_pkg::ST_ANALOG);
		pwr_out.boot_go              = r_r.boot;
		pwr_out.brownout_irq         = r_r.ctrl[pss_pkg::CTRL_BOD_EN] & pwr_in.always_on_low;
		pwr_out.timer_oscillator_en  = 1'b1;
	end

	assign reg_rdata = r_r.rdata;
	assign analog_pd = r_r.apd;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_bat_arm;
		$rose(r_r.bat_armed) |-> $past(rst_rise | pwr_in.field_ok);
	endproperty
	a_bat_arm: assert property (p_bat_arm) else $error("battery armed without trigger");

	property p_bat_prio;
		r_r.bat_armed && pwr_in.bat_ok && pwr_in.field_ok |->
			pwr_out.battery_power_switch && !pwr_out.source_field;
	endproperty
	a_bat_prio: assert property (p_bat_prio) else $error("field chosen over battery");

	property p_field_fallback;
		!r_r.auto_dis && !pwr_in.bat_ok && pwr_in.field_ok |-> pwr_out.source_field;
	endproperty
	a_field_fallback: assert property (p_field_fallback) else $error("no field fallback");

	property p_forced_bat;
		r_r.auto_dis && r_r.bat_armed |-> !pwr_out.comparator_en && !pwr_out.source_field;
	endproperty
	a_forced_bat: assert property (p_forced_bat) else $error("battery not forced");

	property p_bat_off;
		wr_pcon && reg_wdata[pss_pkg::PCON_BAT_OFF] && !pwr_in.field_ok && !rst_rise
			##1 !pwr_in.field_ok && !rst_rise |-> !pwr_out.battery_power_switch;
	endproperty
	a_bat_off: assert property (p_bat_off) else $error("battery switch stayed closed");

	property p_dpd_regs;
		r_r.state == pss_pkg::ST_DPD |->
			!pwr_out.core_regulator_en && !pwr_out.analog_regulator_en && r_r.dpd_flag;
	endproperty
	a_dpd_regs: assert property (p_dpd_regs) else $error("regulator on in power-down");

	property p_seq_order;
		r_r.state == pss_pkg::ST_OFF && powered ##1 powered |=>
			r_r.state == pss_pkg::ST_ANALOG;
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("sequence order broken");

	property p_por_release;
		$rose(pwr_out.system_por_n) |->
			pwr_out.core_regulator_en && $past(pwr_in.sysosc_stable);
	endproperty
	a_por_release: assert property (p_por_release) else $error("reset released early");

	property p_boot_time;
		pwr_out.boot_go |-> r_r.cnt >= SEQ_N && $past(pwr_in.flash_ready);
	endproperty
	a_boot_time: assert property (p_boot_time) else $error("boot before sequence time");

	property p_dsleep_wake;
		r_r.state == pss_pkg::ST_DSLEEP && pwr_in.start_irq && powered |=>
			r_r.state == pss_pkg::ST_ACTIVE;
	endproperty
	a_dsleep_wake: assert property (p_dsleep_wake) else $error("deep-sleep missed wake");

	property p_dpd_hold;
		r_r.state == pss_pkg::ST_DPD && !dpd_wake && powered |=> r_r.state == pss_pkg::ST_DPD;
	endproperty
	a_dpd_hold: assert property (p_dpd_hold) else $error("power-down left early");

	property p_retain;
		r_r.state == pss_pkg::ST_DPD && !reg_wr |=> $stable(r_r.gp);
	endproperty
	a_retain: assert property (p_retain) else $error("retention lost");

	property p_brownout;
		r_r.ctrl[pss_pkg::CTRL_BOD_EN] && pwr_in.always_on_low ##1 r_r.ctrl[pss_pkg::CTRL_BOD_EN]
			&& pwr_in.always_on_low |-> pwr_out.brownout_irq;
	endproperty
	a_brownout: assert property (p_brownout) else $error("brownout not raised");

	property p_field_src;
		pwr_out.source_field |-> pwr_in.field_ok && !pwr_out.battery_power_switch;
	endproperty
	a_field_src: assert property (p_field_src) else $error("field source without field");

	property p_switch_over;
		r_r.bat_armed && !r_r.auto_dis && $fell(pwr_in.bat_ok) && pwr_in.field_ok |->
			pwr_out.source_field;
	endproperty
	a_switch_over: assert property (p_switch_over) else $error("no switch-over to field");

	property p_field_switch;
		pwr_in.field_ok |-> pwr_out.field_power_switch;
	endproperty
	a_field_switch: assert property (p_field_switch) else $error("field switch open");

	property p_power_loss;
		!powered |=> r_r.state == pss_pkg::ST_OFF;
	endproperty
	a_power_loss: assert property (p_power_loss) else $error("state kept without power");

	property p_ldo_enable;
		r_r.state == pss_pkg::ST_ACTIVE |->
			pwr_out.core_regulator_en == r_r.ctrl[pss_pkg::CTRL_CORE_EN] &&
			pwr_out.analog_regulator_en == r_r.ctrl[pss_pkg::CTRL_ANA_EN];
	endproperty
	a_ldo_enable: assert property (p_ldo_enable) else $error("regulator enable ignored");

	property p_boot_pulse;
		pwr_out.boot_go |=> !pwr_out.boot_go;
	endproperty
	a_boot_pulse: assert property (p_boot_pulse) else $error("boot pulse too long");

	property p_field_boot;
		r_r.state == pss_pkg::ST_OFF && pwr_in.field_ok |=> r_r.state == pss_pkg::ST_CORE;
	endproperty
	a_field_boot: assert property (p_field_boot) else $error("field power did not start");

	property p_timer_osc;
		pwr_out.timer_oscillator_en;
	endproperty
	a_timer_osc: assert property (p_timer_osc) else $error("timer oscillator off");

	property p_gating;
		reg_wr && reg_addr == pss_pkg::OFS_PDCFG |=>
			analog_pd == $past(reg_wdata[pss_pkg::APD_W-1:0]);
	endproperty
	a_gating: assert property (p_gating) else $error("gating not applied");

	property p_sleep_flag;
		r_r.state == pss_pkg::ST_ACTIVE && pwr_in.cpu_sleep_req &&
			r_r.mode_sel == pss_pkg::SEL_SLEEP |=> r_r.sleep_flag;
	endproperty
	a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag not set");

	property p_dpd_flag;
		r_r.state == pss_pkg::ST_ACTIVE && pwr_in.cpu_sleep_req && r_r.mode_sel[1] |=>
			r_r.dpd_flag;
	endproperty
	a_dpd_flag: assert property (p_dpd_flag) else $error("power-down flag not set");

	c_boot: cover property (pwr_out.boot_go);
	c_field_only: cover property (r_r.state == pss_pkg::ST_OFF && pwr_in.field_ok && !pwr_in.bat_ok);
	c_dpd_cycle: cover property (r_r.state == pss_pkg::ST_DPD ##1 r_r.state == pss_pkg::ST_CORE);
	c_switch: cover property ($rose(pwr_out.source_field) && r_r.state == pss_pkg::ST_ACTIVE);
	c_dsleep: cover property (r_r.state == pss_pkg::ST_DSLEEP ##1 r_r.state == pss_pkg::ST_ACTIVE);

endmodule // pss_sequencer

/* dv/pss_analog_model.sv */
`timescale 1ns/100ps
module pss_analog_model (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         bat_present,
	input  wire logic         field_present,
	input  wire logic         rail_sag,
	input  wire logic         slow,
	input  pss_pkg::pss_out_t pwr_out,
	output logic              bat_ok,
	output logic              field_ok,
	output logic              always_on_low,
	output logic              sysosc_stable,
	output logic              flash_ready
);
	logic [3:0] osc_r;
	logic [3:0] fl_r;
	assign bat_ok        = bat_present;
	assign field_ok      = field_present;
	assign always_on_low = rail_sag;
	// oscillator and flash settle only while their regulator stays on
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !pwr_out.core_regulator_en) osc_r <= 4'h0;
		else osc_r <= osc_r + {3'h0, osc_r != 4'hF};
		if (!rst_n || !pwr_out.analog_regulator_en) fl_r <= 4'h0;
		else fl_r <= fl_r + {3'h0, fl_r != 4'hF};
	end
	assign sysosc_stable = osc_r > (slow ? 4'h9 : 4'h1);
	assign flash_ready   = fl_r > (slow ? 4'hB : 4'h2);
endmodule // pss_analog_model

/* dv/pss_sequencer_test.sv */
`timescale 1ns/100ps
module pss_sequencer_test;
	localparam int SEQ  = 20;
	localparam int WAKE = 4;
	logic                      sys_clk;
	logic                      rst_n;
	logic [7:0]                reg_addr;
	logic [31:0]               reg_wdata;
	logic                      reg_wr;
	logic                      reg_rd;
	logic [31:0]               reg_rdata;
	pss_pkg::pss_in_t          pwr_in;
	pss_pkg::pss_out_t         pwr_out;
	logic [pss_pkg::APD_W-1:0] analog_pd;
	logic                      bat_p, fld_p, sag, slow, wake, sreq;
	logic                      b_ok, f_ok, low, osc, fl;
	logic [3:0]                ev;
	int                        fails, total_checks, cyc, n;

	assign pwr_in = {b_ok, f_ok, low, ~ev[0], wake, ev[1], ev[2], ev[3], osc, fl, sreq};
	pss_sequencer #(.SEQ_CYCLES(SEQ), .WAKE_LOW_CYCLES(WAKE)) uut (.sys_clk(sys_clk),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwr_in(pwr_in), .pwr_out(pwr_out),
		.analog_pd(analog_pd));
	pss_analog_model ana (.sys_clk(sys_clk), .rst_n(rst_n), .bat_present(bat_p),
		.field_present(fld_p), .rail_sag(sag), .slow(slow), .pwr_out(pwr_out),
		.bat_ok(b_ok), .field_ok(f_ok), .always_on_low(low), .sysosc_stable(osc),
		.flash_ready(fl));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			$display("unexpected at %0t: run did not finish", $time);
			give_verdict;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic look;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e, "read data");
	endtask
	task automatic st(input pss_pkg::pss_state_t s);
		rd(pss_pkg::OFS_STAT, 32'h0000_0700, {21'h0, s, 8'h00});
	endtask
	task automatic pulse(input int k);
		@(posedge sys_clk);
		ev <= 4'h1 << k;
		@(posedge sys_clk);
		ev <= 4'h0;
	endtask
	task automatic enter(input logic [1:0] mode);
		wr(pss_pkg::OFS_PCON, {30'h0, mode});
		@(posedge sys_clk);
		sreq <= 1'b1;
		@(posedge sys_clk);
		sreq <= 1'b0;
	endtask
	// order and timing of the power-up walk, counted from the trigger
	task automatic boot(input int min);
		n = 0;
		do begin
			look;
			n++;
			chk(pwr_out.analog_regulator_en & ~pwr_out.core_regulator_en, 0, "ldo order");
			chk(pwr_out.system_por_n & ~(pwr_out.core_regulator_en & osc), 0, "por");
		end while (pwr_out.boot_go !== 1'b1 && n < 100);
		chk(pwr_out.boot_go & fl, 1, "boot");
		chk(n >= min, 1, "boot time");
	endtask

	initial begin
		rst_n = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, fld_p, sag, slow, sreq, ev} = '0;
		{bat_p, wake} = 2'b11;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(pss_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0018);
		rd(pss_pkg::OFS_PDCFG, 32'hFFFF_FFFF, 32'h0000_00FF);
		rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		st(pss_pkg::ST_OFF);
		chk(pwr_out.battery_power_switch, 0, "switch open");
		pulse(0);
		boot(SEQ);
		chk(pwr_out.battery_power_switch, 1, "switch closed");
		fld_p <= 1'b1;
		look;
		chk(pwr_out.field_power_switch, 1, "field switch");
		chk(pwr_out.source_field, 0, "battery first");
		bat_p <= 1'b0;
		look;
		chk(pwr_out.source_field, 1, "to field");
		st(pss_pkg::ST_ACTIVE);
		wr(pss_pkg::OFS_PCON, 32'h0000_0010);
		look;
		chk({pwr_out.comparator_en, pwr_out.source_field}, 0, "forced battery");
		wr(pss_pkg::OFS_PCON, 32'h0000_0000);
		bat_p <= 1'b1;
		look;
		chk({pwr_out.comparator_en, pwr_out.source_field}, 2, "back to battery");
		sag <= 1'b1;
		look;
		chk(pwr_out.brownout_irq, 0, "brownout off");
		wr(pss_pkg::OFS_CTRL, 32'h0000_0019);
		look;
		chk(pwr_out.brownout_irq, 1, "brownout");
		sag <= 1'b0;
		look;
		chk(pwr_out.brownout_irq, 0, "brownout gone");
		wr(pss_pkg::OFS_CTRL, 32'h0000_0008);
		look;
		chk({pwr_out.core_regulator_en, pwr_out.analog_regulator_en}, 2, "core only");
		wr(pss_pkg::OFS_CTRL, 32'h0000_001A);
		wr(pss_pkg::OFS_PDCFG, 32'h0000_005A);
		look;
		chk(analog_pd, 8'h5A, "gating");
		for (int i = 0; i < 5; i++) begin
			wr(pss_pkg::OFS_GP0 + 8'(4 * i), 32'hA5A5_0000 + i);
		end
		// reset pin, RTC, watchdog and start IRQ wakes once each, alternating sleep and deep-sleep
		for (int k = 0; k < 4; k++) begin
			enter(k[1:0] & 2'h1);
			st(k[0] ? pss_pkg::ST_DSLEEP : pss_pkg::ST_SLEEP);
			chk({pwr_out.core_regulator_en, pwr_out.analog_regulator_en}, 3, "ldo on");
			pulse(k);
			st(pss_pkg::ST_ACTIVE);
			rd(pss_pkg::OFS_PCON, 32'h0000_000C, 32'h0000_0004);
			wr(pss_pkg::OFS_PCON, 32'h0000_0004);
		end
		enter(2'h2);
		look;
		chk({pwr_out.core_regulator_en, pwr_out.analog_regulator_en}, 0, "ldo off");
		rd(pss_pkg::OFS_PCON, 32'h0000_000C, 32'h0000_0008);
		pulse(2);
		pulse(3);
		st(pss_pkg::ST_DPD);
		slow <= 1'b1;
		wake <= 1'b0;
		repeat (WAKE - 1) @(posedge sys_clk);
		wake <= 1'b1;
		st(pss_pkg::ST_DPD);
		wake <= 1'b0;
		repeat (WAKE + 1) @(posedge sys_clk);
		wake <= 1'b1;
		boot(SEQ);
		for (int i = 0; i < 5; i++) begin
			rd(pss_pkg::OFS_GP0 + 8'(4 * i), 32'hFFFF_FFFF, 32'hA5A5_0000 + i);
		end
		wr(pss_pkg::OFS_PCON, 32'h0000_0020);
		look;
		chk(pwr_out.battery_power_switch, 1, "off refused");
		fld_p <= 1'b0;
		// battery stays present so only the command can open the switch
		wr(pss_pkg::OFS_PCON, 32'h0000_0020);
		look;
		chk(pwr_out.battery_power_switch, 0, "battery off");
		st(pss_pkg::ST_OFF);
		bat_p <= 1'b0;
		fld_p <= 1'b1;
		boot(SEQ);
		chk(pwr_out.source_field & pwr_out.field_power_switch, 1, "field boot");
		chk(pwr_out.timer_oscillator_en, 1, "timer osc");
		give_verdict;
	end
endmodule // pss_sequencer_test
